/* hw/psw_defines.svh */
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PSW_REG_REFRESH  8'h00
`define PSW_REG_START    8'h04
`define PSW_REG_PROTECT  8'h08
`define PSW_REG_OPTION   8'h0C
`define PSW_REG_COUNT    8'h10
`define PSW_REG_MON2     8'h14
`define PSW_REG_ISTAT    8'h18
`define PSW_REG_IMASK    8'h1C

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define PSW_DETECT_BIT   3
`define PSW_EV_UFL       0
`define PSW_EV_REFUSE    1
`define PSW_IMASK_RST    2'h0
`define PSW_REFRESH_A    8'h00
`define PSW_REFRESH_B    8'hFF
`define PSW_RELOAD_00    14'h03FF
`define PSW_RELOAD_01    14'h0FFF
`define PSW_RELOAD_10    14'h1FFF
`define PSW_RELOAD_11    14'h3FFF
`define PSW_RESP_OKAY    2'h0
`define PSW_RESP_SLVERR  2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSW_SYS_HZ       40000000
`define PSW_OSC_HZ       125000
`define PSW_OSC_DIV      (`PSW_SYS_HZ / `PSW_OSC_HZ)

`endif

/* hw/psw_pkg.sv */
// ----------------------------------------
// Types for the protected watchdog
// ----------------------------------------
package psw_pkg;

   // Option word one, latched while reset is high
   typedef struct packed {
      logic [5:0] rsvd;
      logic       prot_at_reset;
      logic       stopped_after_reset_opt;
   } psw_opt1_type;

   // Option word two: reload and window selects
   typedef struct packed {
      logic [3:0] rsvd;
      logic       refresh_window_sel_hi;
      logic       refresh_window_sel_lo;
      logic       reload_select_hi;
      logic       reload_select_lo;
   } psw_opt2_type;

   // Counter run state
   typedef enum logic {
      PSW_STOPPED  = 1'b0,
      PSW_COUNTING = 1'b1
   } psw_run_type;

   // Refresh sequence state
   typedef enum logic {
      PSW_SEQ_IDLE  = 1'b0,
      PSW_SEQ_ARMED = 1'b1
   } psw_seq_type;

endpackage : psw_pkg

/* hw/psw_wd_osc.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Dedicated watchdog oscillator tick source
// ----------------------------------------
module psw_wd_osc #(
   parameter int DIV = 320
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic run,
   output logic      dedicated_wd_osc_clock
);

   localparam int DW = $clog2(DIV);

   logic [DW-1:0] div_q;   // Divider phase

   // Divider; held at zero while stopped so a start begins a full cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst || !run)
      begin
         div_q <= '0;
         dedicated_wd_osc_clock <= 1'b0;
      end
      else if (div_q == DW'(DIV - 1))
      begin
         div_q <= '0;
         dedicated_wd_osc_clock <= 1'b1;
      end
      else
      begin
         div_q <= div_q + 1'b1;
         dedicated_wd_osc_clock <= 1'b0;
      end
   end

endmodule : psw_wd_osc

`default_nettype wire

/* hw/psw_top.sv */
// Summary of operation
// (RULE1) Counter runs from dedicated oscillator, not CPU
// (RULE2) Decrement once per oscillator cycle
// (RULE3) Two-bit option selects reload; 00b gives 03FFh
// (RULE4) Reload on 00h/FFh sequence, reset, underflow
// (RULE5) Stop-after-reset option: wait for start write
// (RULE6) Otherwise start counting right after reset
// (RULE7) Once started, counting never halts
// (RULE8) Stop mode refused while protection enabled
// (RULE9) Underflow always raises watchdog reset
// (RULE10) Oscillator runs whenever protection bit is one; here it is also held until run_q reaches counting
// (RULE11) Watchdog interrupt is non-maskable
// (RULE12) Three sources share one interrupt vector
// (RULE13) Detect flag set on interrupt, cleared writing 0
// (RULE14) Software refreshes after watchdog interrupt
// (RULE15) FFh refreshes only right after 00h
// (RULE16) Reload option used only in protection mode
// (RULE17) Refresh accepted only inside selected window; here any refresh passes while the counter is not counting
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psw_defines.svh"

module psw_top #(
   parameter int OSC_DIV = `PSW_OSC_DIV,
   parameter int CNT_W   = 14
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic [7:0]          awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [7:0]          araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   input  wire psw_pkg::psw_opt1_type option_word_one,
   input  wire psw_pkg::psw_opt2_type option_word_two,
   input  wire logic                stop_req,
   output logic                     stop_grant,
   input  wire logic                osc_detect_evt,
   input  wire logic                mon2_evt,
   output logic                     wdt_reset,
   output logic                     shared_nmi,
   output logic                     irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic dec_ok(input logic [7:0] a);
      case (a)
         `PSW_REG_REFRESH, `PSW_REG_START, `PSW_REG_PROTECT,
         `PSW_REG_OPTION, `PSW_REG_COUNT, `PSW_REG_MON2,
         `PSW_REG_ISTAT, `PSW_REG_IMASK: dec_ok = 1'b1;
         default: dec_ok = 1'b0;
      endcase
   endfunction : dec_ok

   // Reload value from the option field
   function automatic logic [CNT_W-1:0] reload_of(input logic [1:0] s);
      case (s)
         2'b00:   reload_of = CNT_W'(`PSW_RELOAD_00);
         2'b01:   reload_of = CNT_W'(`PSW_RELOAD_01);
         2'b10:   reload_of = CNT_W'(`PSW_RELOAD_10);
         default: reload_of = CNT_W'(`PSW_RELOAD_11);
      endcase
   endfunction : reload_of

   // ----------------------------------------
   // State
   // ----------------------------------------
   psw_pkg::psw_opt1_type opt1_q;     // Latched option word one
   psw_pkg::psw_opt2_type opt2_q;     // Latched option word two
   psw_pkg::psw_run_type  run_q;      // Counting or held
   psw_pkg::psw_seq_type  seq_q;      // Refresh sequence
   logic                  prot_q;     // source_protect_en
   logic                  post_rst_q; // First cycle after reset
   logic [CNT_W-1:0]      cnt_q;      // Down-counter
   logic                  detect_q;   // wd_detect_flag
   logic [1:0]            istat_q;    // Sticky events
   logic [1:0]            imask_q;    // Event mask
   logic                  aw_q, w_q;  // Write halves held
   logic [7:0]            waddr_q;    // Held write address
   logic [31:0]           wdata_q;    // Held write data
   logic [3:0]            wstrb_q;    // Held strobes
   logic                  tick;       // Oscillator cycle
   logic [CNT_W-1:0]      reload;     // Active reload value
   logic [CNT_W-1:0]      win_lim;    // Refresh window limit
   logic                  counting;   // Counter advancing
   logic                  wr_fire;    // Register write now
   logic                  wr_ref;     // Byte to refresh_reg
   logic                  refresh_ok; // Accepted refresh
   logic                  refused;    // Refresh out of window
   logic                  ufl_evt;    // Underflow this cycle

   // ----------------------------------------
   // Decode and reload
   // ----------------------------------------
   // Reload field honoured only with protection on [RULE16]
   assign reload = prot_q ?
      reload_of({opt2_q.reload_select_hi,
                 opt2_q.reload_select_lo}) :          // [RULE3]
      CNT_W'(`PSW_RELOAD_00);

   // Window limit as a share of the full period [RULE17]
   always_comb
   begin
      case ({opt2_q.refresh_window_sel_hi,
             opt2_q.refresh_window_sel_lo})
         2'b00:   win_lim = reload;
         2'b01:   win_lim = reload - (reload >> 2);
         2'b10:   win_lim = reload >> 1;
         default: win_lim = reload >> 2;
      endcase
   end

   assign counting = (run_q == psw_pkg::PSW_COUNTING) && prot_q;
   assign wr_fire  = aw_q && w_q && !bvalid;
   assign wr_ref   = wr_fire && wstrb_q[0]
                     && (waddr_q == `PSW_REG_REFRESH);
   // Second byte accepted only after the first [RULE15]
   assign refresh_ok = wr_ref && (seq_q == psw_pkg::PSW_SEQ_ARMED)
                     && (wdata_q[7:0] == `PSW_REFRESH_B)
                     && (!counting || cnt_q <= win_lim); // [RULE17]
   assign refused  = wr_ref && (seq_q == psw_pkg::PSW_SEQ_ARMED)
                     && (wdata_q[7:0] == `PSW_REFRESH_B)
                     && !refresh_ok;
   // Underflow on the tick that would pass one [RULE2]
   assign ufl_evt  = counting && tick && (cnt_q <= CNT_W'(1));

   // ----------------------------------------
   // Oscillator
   // ----------------------------------------
   // Runs whenever protection is on and the count is live;
   // held otherwise so the prescaler stops too [RULE10] [RULE1]
   psw_wd_osc #(
      .DIV (OSC_DIV)
   ) u_osc (
      .sys_clk                (sys_clk),
      .rst                    (rst),
      .run                    (counting),
      .dedicated_wd_osc_clock (tick)
   );

   // ----------------------------------------
   // Options and protection
   // ----------------------------------------
   // Nonvolatile words caught while reset is held
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         opt1_q <= option_word_one;
         opt2_q <= option_word_two;
      end
   end

   // Protection bit: can be set by software, never cleared
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         prot_q <= option_word_one.prot_at_reset;
      else if (wr_fire && wstrb_q[0]
               && waddr_q == `PSW_REG_PROTECT && wdata_q[0])
         prot_q <= 1'b1;
   end

   // Marks the cycle after reset release
   always_ff @(posedge sys_clk)
   begin
      post_rst_q <= rst;
   end

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   // No branch returns to stopped outside reset [RULE7]
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         run_q <= psw_pkg::PSW_STOPPED;
      else
      begin
         case (run_q)
            psw_pkg::PSW_STOPPED:
            begin
               // Auto start [RULE6]
               if (post_rst_q && !opt1_q.stopped_after_reset_opt)
                  run_q <= psw_pkg::PSW_COUNTING;
               // Start register write [RULE5]
               else if (wr_fire && waddr_q == `PSW_REG_START)
                  run_q <= psw_pkg::PSW_COUNTING;
            end
            default: run_q <= psw_pkg::PSW_COUNTING;
         endcase
      end
   end

   // Stop mode refused under protection [RULE8]
   assign stop_grant = stop_req && !prot_q;

   // ----------------------------------------
   // Refresh sequence
   // ----------------------------------------
   // Any byte other than 00h disarms [RULE15]
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         seq_q <= psw_pkg::PSW_SEQ_IDLE;
      else if (wr_ref)
      begin
         if (wdata_q[7:0] == `PSW_REFRESH_A)
            seq_q <= psw_pkg::PSW_SEQ_ARMED;
         else
            seq_q <= psw_pkg::PSW_SEQ_IDLE;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Reload on reset, refresh and underflow [RULE4]
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cnt_q <= CNT_W'(`PSW_RELOAD_00);
      else if (post_rst_q || refresh_ok || ufl_evt)
         cnt_q <= reload;
      else if (counting && tick)
         cnt_q <= cnt_q - 1'b1;                       // [RULE2]
   end

   // Underflow always resets the system [RULE9]
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         wdt_reset <= 1'b0;
      else
         wdt_reset <= ufl_evt;
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   // Detect flag; set wins over a clearing write [RULE13]
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         detect_q <= 1'b0;
      else if (ufl_evt)
         detect_q <= 1'b1;
      else if (wr_fire && wstrb_q[0] && waddr_q == `PSW_REG_MON2
               && !wdata_q[`PSW_DETECT_BIT])
         detect_q <= 1'b0;
   end

   // Shared vector, no mask applies [RULE11] [RULE12]
   assign shared_nmi = wdt_reset || osc_detect_evt || mon2_evt;

   // Sticky events, write one to clear, set wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         istat_q <= 2'h0;
      else
      begin
         if (wr_fire && wstrb_q[0] && waddr_q == `PSW_REG_ISTAT)
            istat_q <= istat_q & ~wdata_q[1:0];
         if (ufl_evt)
            istat_q[`PSW_EV_UFL] <= 1'b1;
         if (refused)
            istat_q[`PSW_EV_REFUSE] <= 1'b1;
      end
   end

   // Event mask
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         imask_q <= `PSW_IMASK_RST;
      else if (wr_fire && wstrb_q[0] && waddr_q == `PSW_REG_IMASK)
         imask_q <= wdata_q[1:0];
   end

   assign irq = |(istat_q & imask_q);

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign awready = !aw_q && !bvalid;
   assign wready  = !w_q && !bvalid;

   // Address and data may arrive in either order
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         aw_q    <= 1'b0;
         w_q     <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `PSW_RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_q    <= 1'b1;
            waddr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_q     <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire)
         begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= dec_ok(waddr_q) ? `PSW_RESP_OKAY
                                      : `PSW_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign arready = !rvalid;

   // One-cycle registered read
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `PSW_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= dec_ok(araddr) ? `PSW_RESP_OKAY : `PSW_RESP_SLVERR;
         rdata  <= 32'h0000_0000;
         case (araddr)
            `PSW_REG_PROTECT: rdata[0]   <= prot_q;
            `PSW_REG_OPTION:  rdata[15:0] <= {opt2_q, opt1_q};
            `PSW_REG_COUNT:   rdata[CNT_W-1:0] <= cnt_q;
            `PSW_REG_MON2:
               rdata[`PSW_DETECT_BIT] <= detect_q;
            `PSW_REG_ISTAT:   rdata[1:0] <= istat_q;
            `PSW_REG_IMASK:   rdata[1:0] <= imask_q;
            // Write-only and unmapped read as zero
            default:          rdata <= 32'h0000_0000;
         endcase
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_ufl_reset: assert property ( // [RULE9]
      ufl_evt |=> wdt_reset)
      else $error("underflow without watchdog reset");

   chk_ufl_reload: assert property ( // [RULE4]
      ufl_evt |=> cnt_q == $past(reload))
      else $error("counter not reloaded after underflow");

   chk_lone_ff: assert property ( // [RULE15]
      (wr_ref && seq_q == psw_pkg::PSW_SEQ_IDLE && !tick
       && !post_rst_q) |=> $stable(cnt_q))
      else $error("unarmed FFh write changed the counter");

   chk_no_stop: assert property ( // [RULE8]
      prot_q |-> !stop_grant)
      else $error("stop granted under protection");

   chk_keeps_count: assert property ( // [RULE7]
      (counting && tick && !refresh_ok && !ufl_evt)
      |=> cnt_q == $past(cnt_q) - 1'b1 ##1 counting)
      else $error("counter failed to advance");

   chk_held_stop: assert property ( // [RULE5]
      (run_q == psw_pkg::PSW_STOPPED && !post_rst_q && !refresh_ok)
      |=> $stable(cnt_q))
      else $error("counter moved while held");

   chk_auto_start: assert property ( // [RULE6]
      (post_rst_q && !opt1_q.stopped_after_reset_opt)
      |=> run_q == psw_pkg::PSW_COUNTING)
      else $error("no automatic start after reset");

   chk_detect_set: assert property ( // [RULE13]
      ufl_evt |=> detect_q [*2])
      else $error("detect flag not held after underflow");

   chk_nmi_shared: assert property ( // [RULE12]
      (wdt_reset || mon2_evt || osc_detect_evt) |-> shared_nmi)
      else $error("shared vector not raised");

   chk_tick_prot: assert property ( // [RULE10]
      tick |-> $past(counting))
      else $error("oscillator ran without protection");

   chk_reload_00: assert property ( // [RULE3]
      (prot_q && !opt2_q.reload_select_hi
       && !opt2_q.reload_select_lo) |-> reload == 14'h03FF)
      else $error("wrong reload for select 00b");

   chk_window: assert property ( // [RULE17]
      refused |-> counting && cnt_q > win_lim)
      else $error("refresh refused inside window");

   cov_underflow: cover property (ufl_evt ##1 wdt_reset);
   cov_refresh:   cover property (refresh_ok);
   cov_refused:   cover property (refused);
   cov_started:   cover property (
      run_q == psw_pkg::PSW_STOPPED ##1 counting);

endmodule : psw_top

`default_nettype wire

/* bench/protected_source_watchdog_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module protected_source_watchdog_bench;

   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready  = 1'b1, rready = 1'b1; // Responses always taken
   logic [3:0]  wstrb   = 4'hF;
   logic        stop_req = 1'b0, osc_detect_evt = 1'b0, mon2_evt = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        stop_grant, wdt_reset, shared_nmi, irq;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, rd;
   psw_pkg::psw_opt1_type option_word_one = 8'h00;
   psw_pkg::psw_opt2_type option_word_two = 8'h00;
   logic [13:0] rl [4] = '{14'h03FF, 14'h0FFF, 14'h1FFF, 14'h3FFF};
   int          bad_count   = 0;
   int          comparisons = 0;
   int          n;

   // Short prescale keeps an underflow near four thousand cycles
   psw_top #(.OSC_DIV(4)) u_psw_top (
      .sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .option_word_one(option_word_one), .option_word_two(option_word_two),
      .stop_req(stop_req), .stop_grant(stop_grant),
      .osc_detect_evt(osc_detect_evt), .mon2_evt(mon2_evt),
      .wdt_reset(wdt_reset), .shared_nmi(shared_nmi), .irq(irq)
   );

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Compare and count; unknowns never match
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   // One when v lies in the closed range, unknown stays unknown
   function automatic logic [31:0] in_rng(input logic [31:0] v, lo, hi);
      return {31'h0, (v >= lo) && (v <= hi)};
   endfunction : in_rng

   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : cyc

   // Handshakes judged at the falling edge, where nothing is moving
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   k;
      logic got, aw_on, w_on;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      got = 1'b0;
      k   = 0;
      while (!got && k < 100)
      begin
         @(negedge sys_clk);
         aw_on = awvalid && awready;
         w_on  = wvalid && wready;
         got   = bvalid;
         rs    = bresp;
         @(posedge sys_clk);
         if (aw_on) awvalid <= 1'b0;
         if (w_on) wvalid <= 1'b0;
         k++;
      end
      if (!got) check(32'h0, 32'h1); // Response never came
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      int   k;
      logic got, ar_on;
      araddr  <= a;
      arvalid <= 1'b1;
      got = 1'b0;
      k   = 0;
      while (!got && k < 100)
      begin
         @(negedge sys_clk);
         ar_on = arvalid && arready;
         got   = rvalid;
         rd    = rdata;
         rs    = rresp;
         @(posedge sys_clk);
         if (ar_on) arvalid <= 1'b0;
         k++;
      end
      if (!got) check(32'h0, 32'h1); // Read data never came
   endtask : rd_reg

   // Options are only sampled while reset is high
   task automatic do_reset(input logic [7:0] o1, input logic [7:0] o2);
      rst             <= 1'b1;
      option_word_one <= o1;
      option_word_two <= o2;
      cyc(3);
      rst <= 1'b0;
      cyc(1);
   endtask : do_reset

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // Watchdog on the bench itself
   // ----------------------------------------
   initial
   begin
      #(25 * 30000);
      bad_count++;
      end_of_test();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      @(posedge sys_clk);
      // Stopped after reset, protection on
      do_reset(8'h03, 8'h00);
      cyc(40);
      rd_reg(8'h10);
      check(rd, 32'h3FF);
      rd_reg(8'h0C);
      check(rd, 32'h0003);
      rd_reg(8'h1C);
      check(rd, 32'h0);
      stop_req <= 1'b1;
      @(negedge sys_clk);
      check(stop_grant, 1'b0);
      @(posedge sys_clk);
      wr(8'h04, 32'h0);
      cyc(40);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h3F2, 32'h3F8), 1);
      cyc(360);
      // Lone FFh, and FFh after a broken pair, must not reload
      wr(8'h00, 32'hFF);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h0, 32'h3A0), 1);
      wr(8'h00, 32'h00);
      wr(8'h00, 32'h55);
      wr(8'h00, 32'hFF);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h0, 32'h3A0), 1);
      wr(8'h00, 32'h00);
      wr(8'h00, 32'hFF);
      check(rs, 2'h0);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h3FB, 32'h3FF), 1);
      // Underflow period, measured from the refresh
      wr(8'h00, 32'h00);
      wr(8'h00, 32'hFF);
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (wdt_reset !== 1'b1 && n < 5000);
      check(in_rng(n, 4080, 4100), 1);
      check(shared_nmi, 1'b1);
      check(irq, 1'b0);
      @(posedge sys_clk);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h3F0, 32'h3FF), 1);
      rd_reg(8'h14);
      check(rd[3], 1'b1);
      wr(8'h14, 32'h0);
      rd_reg(8'h14);
      check(rd[3], 1'b0);
      // Software refresh after the watchdog interrupt
      wr(8'h00, 32'h00);
      wr(8'h00, 32'hFF);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h3FD, 32'h3FF), 1);
      rd_reg(8'h18);
      check(rd[0], 1'b1);
      wr(8'h1C, 32'h1);
      check(irq, 1'b1);
      wr(8'h18, 32'h1);
      check(irq, 1'b0);
      // Unmapped places answer with an error
      wr(8'h24, 32'h1);
      check(rs, 2'h2);
      rd_reg(8'h20);
      check(rs, 2'h2);
      check(rd, 32'h0);
      // Other sources on the shared vector
      for (int i = 0; i < 2; i++)
      begin
         osc_detect_evt <= (i == 0);
         mon2_evt       <= (i == 1);
         @(negedge sys_clk);
         check(shared_nmi, 1'b1);
         @(posedge sys_clk);
      end
      // Sources dropped once, so no input is driven twice in a step
      osc_detect_evt <= 1'b0;
      mon2_evt       <= 1'b0;
      // Every reload encoding with automatic start
      for (int k = 0; k < 4; k++)
      begin
         do_reset(8'h02, 8'(k));
         cyc(40);
         rd_reg(8'h10);
         check(in_rng(rd, rl[k] - 12, rl[k] - 8), 1);
      end
      // Protection off: fixed reload, no count, stop allowed
      do_reset(8'h00, 8'h03);
      cyc(40);
      rd_reg(8'h10);
      check(rd, 32'h3FF);
      check(stop_grant, 1'b1);
      wr(8'h08, 32'h1);
      check(stop_grant, 1'b0);
      wr(8'h04, 32'h0);
      cyc(40);
      rd_reg(8'h10);
      check(in_rng(rd, 32'h0, 32'h3FE), 1);
      // Narrowed windows (75, 50, 25): an early refresh is refused
      for (int k = 1; k < 4; k++)
      begin
         do_reset(8'h02, 8'(k << 2));
         wr(8'h00, 32'h00);
         wr(8'h00, 32'hFF);
         rd_reg(8'h18);
         check(rd[1], 1'b1);
      end
      end_of_test();
   end

endmodule : protected_source_watchdog_bench

`default_nettype wire
